//--- tb_timer_timebase_break_control.sv
`timescale 1ns/1ps
module tb_timer_timebase_break_control;
    logic clk_i, rst_i, wr_i, rd_i, cap, fault, line, bout, boen_n, ch, choen, upd;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, v;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    // Ceiling well above the longest filter sweep
    localparam int LIMIT = 60000;
    localparam logic [31:0] EN = 32'h1 << ttbc_pkg::BIT_CTL_EN;
    localparam logic [31:0] RMP = 32'h1 << ttbc_pkg::BIT_CTL_REMAP;
    localparam logic [31:0] INP = 32'h1 << ttbc_pkg::BIT_CTL_INPUT;
    localparam logic [31:0] PRE = 32'h1 << ttbc_pkg::BIT_CTL_PRE;
    localparam logic [31:0] CCE = 32'h1 << ttbc_pkg::BIT_CTL_CCE;
    localparam logic [31:0] UG = 32'h1 << ttbc_pkg::BIT_CTL_UG;
    localparam logic [31:0] CLR = 32'h1 << ttbc_pkg::BIT_CTL_UIFCLR;
    localparam logic [31:0] MAIN_OUTPUT_ENABLE = 32'h1 << ttbc_pkg::BIT_MOE;
    localparam logic [31:0] BREAK_ENABLE = 32'h1 << ttbc_pkg::BIT_BKE;
    localparam logic [31:0] AUTO_OUTPUT_ENABLE = 32'h1 << ttbc_pkg::BIT_AOE;
    localparam logic [31:0] BID = 32'h1 << ttbc_pkg::BIT_BREAK_BIDIRECTIONAL;
    localparam logic [31:0] DSRM = 32'h1 << ttbc_pkg::BIT_BREAK_DISARM;
    // Filter sample divider and event count for each code
    int fdiv[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
    int fn[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};

    ttbc_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capture_input_event_i(cap),
        .break_input_i(line), .break_out_o(bout), .break_oe_n_o(boen_n),
        .channel_output_o(ch), .channel_oen_o(choen), .update_flag_o(upd));
    ttbc_fault_src i_src (.fault_i(fault), .dev_out_i(bout), .dev_oe_n_i(boen_n),
        .line_o(line));

    // Free-running clock at 125 MHz
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        rd(a);
        check(s, v & m, e);
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // Waits for the sticky update flag, bounded
    task automatic wait_upd(output int t);
        int n;
        n = 0;
        do begin
            idle(1);
            n++;
        end while (upd !== 1'b1 && n < 2000);
        t = cyc;
    endtask
    task automatic pulse(input int n);
        @(posedge clk_i);
        fault <= 1'b1;
        repeat (n) @(posedge clk_i);
        fault <= 1'b0;
    endtask

    task automatic t_regs();
        rd_chk("arr rst", ttbc_pkg::OFS_ARR, 32'hFFFF, 32'hFFFF);
        rd_chk("psc rst", ttbc_pkg::OFS_PSC, 32'hFFFF, 32'h0);
        rd_chk("rep rst", ttbc_pkg::OFS_REP, 32'hFFFF, 32'h0);
        rd_chk("ccr rst", ttbc_pkg::OFS_CCR, 32'hFFFF, 32'h0);
        rd_chk("cnt rst", ttbc_pkg::OFS_CNT, 32'hFFFFFFFF, 32'h0);
        rd_chk("bdt rst", ttbc_pkg::OFS_BDT, 32'hFFFFFFFF, 32'h0);
        rd_chk("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0);
        wr(ttbc_pkg::OFS_CTL, UG);
        rd_chk("copy off", ttbc_pkg::OFS_CNT, 32'h80000000, 32'h0);
        wr(ttbc_pkg::OFS_CTL, RMP);
        rd_chk("copy on", ttbc_pkg::OFS_CNT, 32'h80000000, 32'h80000000);
        wr(ttbc_pkg::OFS_CTL, RMP | CLR);
        rd_chk("copy clr", ttbc_pkg::OFS_CNT, 32'h80000000, 32'h0);
        $display("test regs done");
    endtask
    // Reload 9, prescale 3: one update each 40 cycles once the prescale is active
    task automatic t_timebase();
        int t0, t1, t2, t3, t4;
        logic [31:0] c0;
        wr(ttbc_pkg::OFS_ARR, 32'h9);
        wr(ttbc_pkg::OFS_PSC, 32'h3);
        wr(ttbc_pkg::OFS_CTL, EN | CLR);
        t0 = cyc;
        wait_upd(t1);
        check("first short", 32'(t1 - t0 < 20), 32'h1);
        wr(ttbc_pkg::OFS_CTL, EN | CLR);
        wait_upd(t2);
        check("period", 32'(t2 - t1), 32'd40);
        wr(ttbc_pkg::OFS_REP, 32'h2);
        wr(ttbc_pkg::OFS_CTL, EN | CLR);
        wait_upd(t3);
        check("rep late", 32'(t3 - t2), 32'd40);
        wr(ttbc_pkg::OFS_CTL, EN | CLR);
        wait_upd(t4);
        check("rep period", 32'(t4 - t3), 32'd120);
        wr(ttbc_pkg::OFS_ARR, 32'h0);
        rd(ttbc_pkg::OFS_CNT);
        c0 = v;
        idle(20);
        rd_chk("held", ttbc_pkg::OFS_CNT, 32'hFFFF, c0 & 32'hFFFF);
        wr(ttbc_pkg::OFS_CTL, 32'h0);
        wr(ttbc_pkg::OFS_ARR, 32'h9);
        $display("test timebase done");
    endtask
    task automatic t_compare();
        wr(ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE);
        wr(ttbc_pkg::OFS_CTL, CCE);
        wr(ttbc_pkg::OFS_CNT, 32'h5);
        wr(ttbc_pkg::OFS_CCR, 32'h8);
        idle(3);
        check("direct hi", {31'h0, ch}, 32'h1);
        check("oen on", {31'h0, choen}, 32'h1);
        wr(ttbc_pkg::OFS_CCR, 32'h3);
        idle(3);
        check("direct lo", {31'h0, ch}, 32'h0);
        wr(ttbc_pkg::OFS_CTL, CCE | PRE);
        wr(ttbc_pkg::OFS_CCR, 32'h8);
        idle(3);
        check("preload held", {31'h0, ch}, 32'h0);
        wr(ttbc_pkg::OFS_CTL, CCE | PRE | UG);
        idle(3);
        check("preload moved", {31'h0, ch}, 32'h1);
        wr(ttbc_pkg::OFS_BDT, 32'h0);
        idle(3);
        check("oen off", {31'h0, choen}, 32'h0);
        wr(ttbc_pkg::OFS_CTL, INP | CCE);
        wr(ttbc_pkg::OFS_CNT, 32'h33);
        @(posedge clk_i);
        cap <= 1'b1;
        @(posedge clk_i);
        cap <= 1'b0;
        idle(2);
        rd_chk("capture", ttbc_pkg::OFS_CCR, 32'hFFFF, 32'h33);
        $display("test compare done");
    endtask
    task automatic t_break();
        int n;
        wr(ttbc_pkg::OFS_CTL, CCE);
        wr(ttbc_pkg::OFS_BDT, BID | BREAK_ENABLE | MAIN_OUTPUT_ENABLE | AUTO_OUTPUT_ENABLE);
        pulse(4);
        idle(4);
        check("line pulled", {31'h0, boen_n}, 32'h0);
        check("oen idle", {31'h0, choen}, 32'h0);
        wr(ttbc_pkg::OFS_CTL, CCE | UG);
        rd_chk("moe cleared", ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE, 32'h0);
        // Software releases the line, then polls until the fault is gone
        wr(ttbc_pkg::OFS_BDT, BID | BREAK_ENABLE | AUTO_OUTPUT_ENABLE | DSRM);
        idle(3);
        check("released", {31'h0, boen_n}, 32'h1);
        n = 0;
        do begin
            rd(ttbc_pkg::OFS_BDT);
            n++;
        end while (v[ttbc_pkg::BIT_BREAK_DISARM] !== 1'b0 && n < 20);
        check("disarm clr", v & DSRM, 32'h0);
        wr(ttbc_pkg::OFS_CTL, CCE | UG);
        rd_chk("auto moe", ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE, MAIN_OUTPUT_ENABLE);
        $display("test break done");
    endtask
    task automatic t_filter();
        int d, g;
        wr(ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE);
        pulse(10);
        rd_chk("bke gate", ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE, MAIN_OUTPUT_ENABLE);
        wr(ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE | BREAK_ENABLE | (32'h1 << ttbc_pkg::BIT_BKP));
        rd_chk("pol high", ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE, 32'h0);
        for (int c = 0; c < 16; c++) begin
            d = fdiv[c] * ttbc_pkg::DTS_DIV;
            g = (c == 0) ? 1 : (fn[c] - 2) * d + 1;
            wr(ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE | BREAK_ENABLE | (32'(c) << ttbc_pkg::BIT_BKF_LO));
            idle(fn[c] * d + 6);
            pulse(g);
            idle(fn[c] * d + 6);
            rd_chk("glitch", ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE, (c == 0) ? 32'h0 : MAIN_OUTPUT_ENABLE);
            pulse(fn[c] * d + 8);
            idle(fn[c] * d + 8);
            rd_chk("fault", ttbc_pkg::OFS_BDT, MAIN_OUTPUT_ENABLE, 32'h0);
        end
        $display("test filter done");
    endtask
    task automatic t_lock();
        do_reset();
        wr(ttbc_pkg::OFS_BDT, 32'h00020500);
        wr(ttbc_pkg::OFS_BDT, BID | AUTO_OUTPUT_ENABLE | BREAK_ENABLE | 32'h00053B55);
        rd_chk("locked", ttbc_pkg::OFS_BDT, 32'hFFFFFFFF, 32'h00020900);
        $display("test lock done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        cap = 1'b0;
        fault = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        do_reset();
        t_regs();
        t_timebase();
        t_compare();
        t_break();
        t_filter();
        t_lock();
        tally_and_finish();
    end
endmodule

//--- ttbc_fault_src.sv
`timescale 1ns/1ps
// Outside fault source sharing the open-drain break line with the timer
module ttbc_fault_src (
    // Fault request from the bench
    input wire logic fault_i,
    // Timer side of the pin
    input wire logic dev_out_i,
    input wire logic dev_oe_n_i,
    // Resolved line level
    output logic line_o
);
    // Pull-up keeps the line high; whoever sinks it wins, so it never floats
    assign line_o = !fault_i && (dev_oe_n_i || dev_out_i);
endmodule

//--- ttbc_pkg.sv
package ttbc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CNT = 8'h24;
    localparam logic [7:0] OFS_PSC = 8'h28;
    localparam logic [7:0] OFS_ARR = 8'h2C;
    localparam logic [7:0] OFS_REP = 8'h30;
    localparam logic [7:0] OFS_CCR = 8'h34;
    localparam logic [7:0] OFS_BDT = 8'h44;
    localparam logic [7:0] OFS_CTL = 8'h50;
    localparam logic [7:0] OFS_STA = 8'h54;
    // Reset values
    localparam logic [15:0] ARR_RESET = 16'hFFFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // Break control field positions, plus the update flag copy bit of the counter
    localparam int BIT_BREAK_BIDIRECTIONAL = 28;
    localparam int BIT_BREAK_DISARM = 26;
    localparam int BIT_BKF_LO = 16;
    localparam int BIT_MOE = 15;
    localparam int BIT_AOE = 14;
    localparam int BIT_BKP = 13;
    localparam int BIT_BKE = 12;
    localparam int BIT_RUN_OFFSTATE_SELECT = 11;
    localparam int BIT_IDLE_OFFSTATE_SELECT = 10;
    localparam int BIT_LOCK_LO = 8;
    localparam int BIT_UPDATE_FLAG_COPY = 31;
    // Own control register bits
    localparam int BIT_CTL_EN = 0;
    localparam int BIT_CTL_REMAP = 1;
    localparam int BIT_CTL_INPUT = 2;
    localparam int BIT_CTL_PRE = 3;
    localparam int BIT_CTL_CCE = 4;
    localparam int BIT_CTL_POL = 5;
    localparam int BIT_CTL_UG = 6;
    localparam int BIT_CTL_UIFCLR = 7;
    localparam int BIT_CTL_OIS = 8;
    // Dead-time clock division of the kernel clock
    localparam int DTS_DIV = 1;

    typedef struct packed {
        logic break_bidirectional;
        logic [3:0] break_filter_select;
        logic auto_output_enable;
        logic break_polarity;
        logic break_enable;
        logic run_offstate_select;
        logic idle_offstate_select;
        logic [1:0] lock;
        logic [7:0] dtg;
    } ttbc_brk_t;
endpackage

//--- ttbc_timer.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Counter bit 31 reads update flag copy when remap is on, else zero.
// [RQ2] Counter ticks at input rate divided by prescale value plus one.
// [RQ3] Prescale value reaches active prescaler only at update events, forced included.
// [RQ4] Reload register feeds active reload; resets to all ones.
// [RQ5] Counter holds while reload value is zero.
// [RQ6] Repeat downcounter makes update at zero, then reloads repeat value.
// [RQ7] Repeat value writes take effect at next repeat reload only.
// [RQ8] Repeat value plus one equals PWM periods per update.
// [RQ9] Compare write goes direct without preload, else at update event.
// [RQ10] Active compare versus counter drives the channel output.
// [RQ11] Input mode: compare register holds counter at last capture.
// [RQ12] Bidirectional break: active break pulls break line low, open drain.
// [RQ13] Bidirectional and disarm writes take effect one cycle later.
// [RQ14] Disarm bit disarms break; hardware clears it when no break remains.
// [RQ15] Software sets disarm to release the line, then polls until cleared.
// [RQ16] Break filter needs N equal samples; code zero bypasses filtering.
// [RQ17] Filter codes pick sample rate and N as tabulated.
// [RQ18] Bidirectional, filter and auto enable ignore writes at lock level one up.
// [RQ19] Software should program all lockable fields in its first write.
// [RQ20] Break clears main output enable immediately.
// [RQ21] Main output enable gates outputs; off state follows idle selection.
// [RQ22] Auto enable sets main output enable at update if break inactive.
// [RQ23] Polarity picks break active level; break enable gates break action.
// [RQ24] Lock field accepts only the first write after reset.
// [RQ25] Lock levels freeze more fields: level one, two, three. Level three freezes the same fields as level two.
// [RQ26] Counter counts zero to reload, wraps, decrements repeat downcounter.
module ttbc_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Capture event, same clock domain
    input wire logic capture_input_event_i,
    // Break pin, open drain
    input wire logic break_input_i,
    output logic break_out_o,
    output logic break_oe_n_o,
    // Channel output and update flag
    output logic channel_output_o,
    output logic channel_oen_o,
    output logic update_flag_o
);
    // Write strobes
    wire logic wr_cnt = wr_i && addr_i == ttbc_pkg::OFS_CNT;
    wire logic wr_psc = wr_i && addr_i == ttbc_pkg::OFS_PSC;
    wire logic wr_arr = wr_i && addr_i == ttbc_pkg::OFS_ARR;
    wire logic wr_rep = wr_i && addr_i == ttbc_pkg::OFS_REP;
    wire logic wr_ccr = wr_i && addr_i == ttbc_pkg::OFS_CCR;
    wire logic wr_bdt = wr_i && addr_i == ttbc_pkg::OFS_BDT;
    wire logic wr_ctl = wr_i && addr_i == ttbc_pkg::OFS_CTL;

    logic [15:0] cnt_reg, psc_reg, psc_act_reg, pre_cnt_reg, arr_reg;
    logic [15:0] ccr_reg, ccr_act_reg;
    logic [7:0] rep_reg, repeat_downcounter_reg;
    logic [8:0] ctl_reg;
    logic uif_reg, moe_reg, dsrm_reg, lock_wr_reg;
    ttbc_pkg::ttbc_brk_t brk_reg;
    logic break_bidirectional_eff_reg, dsrm_eff_reg;
    logic [1:0] brk_sync_reg;
    logic brk_filt_reg;
    logic [3:0] flt_cnt_reg;
    logic [5:0] smp_cnt_reg;
    logic [31:0] rdata_reg;
    logic out_reg, oen_reg, bo_reg, boe_reg;

    // Control decode
    wire logic cen = ctl_reg[ttbc_pkg::BIT_CTL_EN];
    wire logic is_input = ctl_reg[ttbc_pkg::BIT_CTL_INPUT];
    wire logic force_update = wr_ctl && wdata_i[ttbc_pkg::BIT_CTL_UG];
    wire logic lvl1 = brk_reg.lock != 2'b00;
    wire logic lvl2 = brk_reg.lock[1];

    // Prescaler and counter tick
    localparam logic [15:0] ZERO = ttbc_pkg::ZERO16;
    wire logic tick = cen && arr_reg != ZERO && pre_cnt_reg == psc_act_reg; // RQ2 RQ5
    wire logic wrap = tick && cnt_reg >= arr_reg; // RQ26
    wire logic rep_zero = repeat_downcounter_reg == 8'h00;
    // Update event: overflow with repeat counter at zero, or forced
    wire logic upd = (wrap && rep_zero) || force_update; // RQ6 RQ8

    // Break sampling: select N and sample divider from filter code
    function automatic logic [9:0] flt_cfg(input logic [3:0] c);
        case (c)
            4'h1: flt_cfg = {6'd0, 4'd2};
            4'h2: flt_cfg = {6'd0, 4'd4};
            4'h3: flt_cfg = {6'd0, 4'd8};
            4'h4: flt_cfg = {6'd1, 4'd6};
            4'h5: flt_cfg = {6'd1, 4'd8};
            4'h6: flt_cfg = {6'd3, 4'd6};
            4'h7: flt_cfg = {6'd3, 4'd8};
            4'h8: flt_cfg = {6'd7, 4'd6};
            4'h9: flt_cfg = {6'd7, 4'd8};
            4'hA: flt_cfg = {6'd15, 4'd5};
            4'hB: flt_cfg = {6'd15, 4'd6};
            4'hC: flt_cfg = {6'd15, 4'd8};
            4'hD: flt_cfg = {6'd31, 4'd5};
            4'hE: flt_cfg = {6'd31, 4'd6};
            4'hF: flt_cfg = {6'd31, 4'd8};
            default: flt_cfg = 10'h000;
        endcase
    endfunction
    wire logic [9:0] cfg = flt_cfg(brk_reg.break_filter_select); // RQ17
    wire logic smp = smp_cnt_reg >= cfg[9:4];
    // Raw active level after polarity, async path when unfiltered
    wire logic raw_act = (break_input_i == brk_reg.break_polarity);
    wire logic syn_act = (brk_sync_reg[1] == brk_reg.break_polarity);
    wire logic flt_act = (brk_reg.break_filter_select == 4'h0) ? raw_act : brk_filt_reg; // RQ16
    wire logic brk_act = brk_reg.break_enable && flt_act; // RQ23
    wire logic break_event = brk_act && !dsrm_eff_reg; // RQ14

    // Prescaler, counter and repeat counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_reg <= 16'h0000;
            cnt_reg <= 16'h0000;
            psc_act_reg <= 16'h0000;
            repeat_downcounter_reg <= 8'h00;
        end else begin
            pre_cnt_reg <= (upd || tick || !cen) ? 16'h0000 : pre_cnt_reg + 16'h0001;
            if (upd) begin
                psc_act_reg <= psc_reg; // RQ3
            end
            if (force_update || wrap) begin
                cnt_reg <= 16'h0000;
            end else if (wr_cnt) begin
                cnt_reg <= wdata_i[15:0];
            end else if (tick) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
            if (upd) begin
                repeat_downcounter_reg <= rep_reg; // RQ7
            end else if (wrap) begin
                repeat_downcounter_reg <= repeat_downcounter_reg - 8'h01; // RQ26
            end
        end
    end

    // Software registers and compare/capture
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            psc_reg <= 16'h0000;
            arr_reg <= ttbc_pkg::ARR_RESET; // RQ4
            rep_reg <= 8'h00;
            ccr_reg <= 16'h0000;
            ccr_act_reg <= 16'h0000;
            ctl_reg <= 9'h000;
            uif_reg <= 1'b0;
        end else begin
            if (wr_psc) psc_reg <= wdata_i[15:0];
            if (wr_arr) arr_reg <= wdata_i[15:0];
            if (wr_rep) rep_reg <= wdata_i[7:0];
            if (wr_ctl) ctl_reg <= {wdata_i[8], 2'b00, wdata_i[5:0]};
            if (is_input) begin
                if (capture_input_event_i && ctl_reg[ttbc_pkg::BIT_CTL_CCE]) begin
                    ccr_reg <= cnt_reg; // RQ11
                end
            end else begin
                if (wr_ccr) ccr_reg <= wdata_i[15:0];
                if (wr_ccr && !ctl_reg[ttbc_pkg::BIT_CTL_PRE]) begin
                    ccr_act_reg <= wdata_i[15:0]; // RQ9
                end else if (upd) begin
                    ccr_act_reg <= ccr_reg; // RQ9
                end
            end
            // Set wins over clear
            if (upd) uif_reg <= 1'b1;
            else if (wr_ctl && wdata_i[ttbc_pkg::BIT_CTL_UIFCLR]) uif_reg <= 1'b0;
        end
    end

    // Break and dead-time register with lock protection
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            brk_reg <= '0;
            lock_wr_reg <= 1'b0;
            dsrm_reg <= 1'b0;
            break_bidirectional_eff_reg <= 1'b0;
            dsrm_eff_reg <= 1'b0;
        end else begin
            if (wr_bdt) begin
                lock_wr_reg <= 1'b1;
                if (!lock_wr_reg) brk_reg.lock <= wdata_i[9:8]; // RQ24
                if (!lvl1) begin
                    brk_reg.break_bidirectional <= wdata_i[ttbc_pkg::BIT_BREAK_BIDIRECTIONAL]; // RQ18
                    brk_reg.break_filter_select <= wdata_i[ttbc_pkg::BIT_BKF_LO +: 4]; // RQ18
                    brk_reg.auto_output_enable <= wdata_i[ttbc_pkg::BIT_AOE]; // RQ18
                    brk_reg.break_polarity <= wdata_i[ttbc_pkg::BIT_BKP]; // RQ25
                    brk_reg.break_enable <= wdata_i[ttbc_pkg::BIT_BKE]; // RQ25
                    brk_reg.dtg <= wdata_i[7:0]; // RQ25
                end
                if (!lvl2) begin
                    brk_reg.run_offstate_select <= wdata_i[ttbc_pkg::BIT_RUN_OFFSTATE_SELECT]; // RQ25
                    brk_reg.idle_offstate_select <= wdata_i[ttbc_pkg::BIT_IDLE_OFFSTATE_SELECT]; // RQ25
                end
            end
            // Hardware clear once no source is active, software set wins
            if (wr_bdt && wdata_i[ttbc_pkg::BIT_BREAK_DISARM]) dsrm_reg <= 1'b1;
            else if (!brk_act) dsrm_reg <= 1'b0; // RQ14
            // One cycle of delay before these bits act
            break_bidirectional_eff_reg <= brk_reg.break_bidirectional; // RQ13
            dsrm_eff_reg <= dsrm_reg; // RQ13
        end
    end

    // Break synchroniser, sample divider and filter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            brk_sync_reg <= 2'b00;
            smp_cnt_reg <= 6'h00;
            flt_cnt_reg <= 4'h0;
            brk_filt_reg <= 1'b0;
        end else begin
            brk_sync_reg <= {brk_sync_reg[0], break_input_i};
            smp_cnt_reg <= smp ? 6'h00 : smp_cnt_reg + 6'h01;
            if (smp) begin
                if (syn_act == brk_filt_reg) begin
                    flt_cnt_reg <= 4'h0;
                end else if (flt_cnt_reg + 4'h1 >= cfg[3:0]) begin
                    brk_filt_reg <= syn_act; // RQ16
                    flt_cnt_reg <= 4'h0;
                end else begin
                    flt_cnt_reg <= flt_cnt_reg + 4'h1;
                end
            end
        end
    end

    // Main output enable: break clears it at once, combinational path
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            moe_reg <= 1'b0;
        end else if (brk_act) begin
            moe_reg <= 1'b0; // RQ20
        end else if (wr_bdt) begin
            moe_reg <= wdata_i[ttbc_pkg::BIT_MOE];
        end else if (upd && brk_reg.auto_output_enable) begin
            moe_reg <= 1'b1; // RQ22
        end
    end
    wire logic moe_now = moe_reg && !brk_act; // RQ20

    // Channel and break pin outputs
    wire logic oc_ref = cnt_reg < ccr_act_reg; // RQ10
    wire logic oc_val = oc_ref ^ ctl_reg[ttbc_pkg::BIT_CTL_POL];
    wire logic ce = ctl_reg[ttbc_pkg::BIT_CTL_CCE] && !is_input;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
            oen_reg <= 1'b0;
            bo_reg <= 1'b0;
            boe_reg <= 1'b1;
        end else begin
            // Enabled output drives compare, idle drives idle level
            out_reg <= moe_now ? (ce & oc_val) : ctl_reg[ttbc_pkg::BIT_CTL_OIS]; // RQ21
            oen_reg <= moe_now ? (ce | brk_reg.run_offstate_select) : (ce & brk_reg.idle_offstate_select); // RQ21
            bo_reg <= 1'b0;
            boe_reg <= !(break_bidirectional_eff_reg && break_event); // RQ12
        end
    end

    // Read mux, data valid in the cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_i) begin
            case (addr_i)
                ttbc_pkg::OFS_CNT: rdata_reg <= {uif_reg & ctl_reg[ttbc_pkg::BIT_CTL_REMAP],
                    15'h0000, cnt_reg}; // RQ1
                ttbc_pkg::OFS_PSC: rdata_reg <= {16'h0000, psc_reg};
                ttbc_pkg::OFS_ARR: rdata_reg <= {16'h0000, arr_reg};
                ttbc_pkg::OFS_REP: rdata_reg <= {24'h000000, rep_reg};
                ttbc_pkg::OFS_CCR: rdata_reg <= {16'h0000, ccr_reg};
                ttbc_pkg::OFS_BDT: rdata_reg <= {3'h0, brk_reg.break_bidirectional, 1'b0, dsrm_reg, 6'h00,
                    brk_reg.break_filter_select, moe_now, brk_reg.auto_output_enable, brk_reg.break_polarity, brk_reg.break_enable,
                    brk_reg.run_offstate_select, brk_reg.idle_offstate_select, brk_reg.lock, brk_reg.dtg};
                ttbc_pkg::OFS_CTL: rdata_reg <= {23'h000000, ctl_reg};
                ttbc_pkg::OFS_STA: rdata_reg <= {24'h000000, repeat_downcounter_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    assign rdata_o = rdata_reg;
    assign channel_output_o = out_reg;
    assign channel_oen_o = oen_reg;
    assign break_out_o = bo_reg;
    assign break_oe_n_o = boe_reg;
    assign update_flag_o = uif_reg;

    // Checks
    chk_zero_reload_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
        (arr_reg == 16'h0000 && !wr_cnt && !force_update) |=> $stable(cnt_reg))
        else $error("counter moved with zero reload");
    chk_psc_only_upd: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
        !$past(upd) |-> $stable(psc_act_reg))
        else $error("active prescale changed without update");
    chk_break_clears_moe: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
        brk_act |=> !moe_reg)
        else $error("main output enable survived break");
    chk_aoe_sets_moe: assert property (@(posedge clk_i) disable iff (rst_i) // RQ22
        (upd && brk_reg.auto_output_enable && !brk_act && !wr_bdt) |=> moe_reg)
        else $error("auto enable did not set main output enable");
    chk_lock_once: assert property (@(posedge clk_i) disable iff (rst_i) // RQ24
        $past(lock_wr_reg) |-> $stable(brk_reg.lock))
        else $error("lock field changed after first write");
    chk_lock_filter: assert property (@(posedge clk_i) disable iff (rst_i) // RQ18
        $past(lvl1) |-> $stable(brk_reg.break_filter_select) && $stable(brk_reg.auto_output_enable))
        else $error("locked field was written");
    chk_rep_reload: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
        upd |=> repeat_downcounter_reg == $past(rep_reg))
        else $error("repeat counter not reloaded at update");
    chk_bidir_pull: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
        (break_bidirectional_eff_reg && break_event) |=> !break_oe_n_o && !break_out_o)
        else $error("break line not pulled low");
    chk_remap_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
        (rd_i && addr_i == ttbc_pkg::OFS_CNT && !ctl_reg[ttbc_pkg::BIT_CTL_REMAP])
        |=> !rdata_o[31])
        else $error("copy bit set with remap off");
endmodule
